//--- rtl/rpts_pkg.sv
package rpts_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS      = 5000;
  localparam int unsigned STRAP_DELAY_NS_X10 = 15;  // 1.5 us in units of 100 ns
  localparam int unsigned STRAP_DELAY_CYC    = (STRAP_DELAY_NS_X10 * 100000) / CLK_PERIOD_PS;
  localparam int unsigned CFG_STEPS_CYC      = 16;   // self-configuration duration
  localparam int unsigned PARK_CYC           = 64;   // fast park sequence duration

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned STRAP_W   = 8;
  localparam logic [7:0]  STRAP_RST = 8'h00;

  typedef enum logic [2:0] {
    RPTS_ST_RESET,
    RPTS_ST_WAIT_STRAP,
    RPTS_ST_CONFIG,
    RPTS_ST_RUN,
    RPTS_ST_PARK,
    RPTS_ST_PARKED
  } rpts_state_t;

  // test pin three-signal carrier
  typedef struct packed {
    logic [STRAP_W-1:0] dout;
    logic [STRAP_W-1:0] oe;
    logic [STRAP_W-1:0] pulldown_en;
  } rpts_pin_drv_t;

  typedef struct packed {
    logic                cfg_busy;
    logic                ready;
    logic                parking;
    logic                parked;
    logic                strap_valid;
    logic [STRAP_W-1:0]  strap_value;
  } rpts_status_t;

endpackage

//--- rtl/rpts_delay_cnt.sv
`timescale 1ns/100ps
`default_nettype none

// one-shot down counter: done pulses once when the loaded count expires
module rpts_delay_cnt #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_ref_clk,  // clock
  input  wire logic         i_resetn,   // async reset, active low
  input  wire logic         i_load,     // load count, start
  input  wire logic [W-1:0] i_count,    // cycles to wait
  output logic              o_busy,     // counting
  output logic              o_done      // one-cycle pulse at expiry
);

  logic [W-1:0] cnt_r;
  logic         busy_r;
  wire          last = busy_r && (cnt_r == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end
    else if (i_load)
    begin
      cnt_r  <= i_count;
      busy_r <= (i_count != '0);
    end
    else if (busy_r)
    begin
      cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      busy_r <= !last;
    end
  end

  assign o_busy = busy_r;
  assign o_done = last;

endmodule

`default_nettype wire

//--- rtl/rpts_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module rpts_ctrl #(
  parameter int unsigned STRAP_W   = rpts_pkg::STRAP_W,
  parameter int unsigned STRAP_CYC = rpts_pkg::STRAP_DELAY_CYC,
  parameter int unsigned CFG_CYC   = rpts_pkg::CFG_STEPS_CYC,
  parameter int unsigned PARK_CYCS = rpts_pkg::PARK_CYC
) (
  input  wire logic                 i_ref_clk,                // 200 MHz reference
  input  wire logic                 i_resetn,                 // async reset, active low
  input  wire logic                 i_power_on_reset_n,       // power-on reset pin, sync
  input  wire logic                 i_fast_park_n,            // fast park request, active low
  input  wire logic                 i_factory_test_enable,    // must stay low
  input  wire logic                 i_scan_port_reset_n,      // must stay low
  input  wire logic [STRAP_W-1:0]   i_test_strap_pin,         // test pin input levels
  input  wire logic [STRAP_W-1:0]   i_test_out_data,          // data to drive after strap
  output rpts_pkg::rpts_pin_drv_t   o_test_strap_drv,         // test pin drive, enable, pulldown
  output rpts_pkg::rpts_status_t    o_status,                 // sequencing status
  output logic                      o_test_mode,              // strap selected test mode
  output logic                      o_micromirror_array_park, // fast park command to array
  output logic                      o_pin_misuse              // test or scan input not low
);

  // ---------------------------------------------------------------
  // state and timers
  // ---------------------------------------------------------------
  rpts_pkg::rpts_state_t state_r, state_nxt;
  logic                  por_q_r;
  logic [STRAP_W-1:0]    strap_r;
  logic                  strap_valid_r;
  logic [STRAP_W-1:0]    dout_r;
  logic                  oe_r;
  logic                  tmr_done;
  logic                  tmr_load;
  logic [15:0]           tmr_count;

  // the pin is a reset too: everything clears while it is low
  wire por_low  = !i_power_on_reset_n;
  wire por_rise = i_power_on_reset_n && !por_q_r;
  wire park_req = !i_fast_park_n;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      por_q_r <= 1'b0;
    else
      por_q_r <= i_power_on_reset_n;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_count = 16'h0000;
    case (state_r)
      rpts_pkg::RPTS_ST_RESET:
        if (por_rise)
        begin
          state_nxt = rpts_pkg::RPTS_ST_WAIT_STRAP;
          tmr_load  = 1'b1;
          tmr_count = 16'(STRAP_CYC);
        end
      rpts_pkg::RPTS_ST_WAIT_STRAP:
        if (tmr_done)
        begin
          state_nxt = rpts_pkg::RPTS_ST_CONFIG;
          tmr_load  = 1'b1;
          tmr_count = 16'(CFG_CYC);
        end
      rpts_pkg::RPTS_ST_CONFIG:
        if (park_req)
        begin
          state_nxt = rpts_pkg::RPTS_ST_PARK;
          tmr_load  = 1'b1;
          tmr_count = 16'(PARK_CYCS);
        end
        else if (tmr_done)
          state_nxt = rpts_pkg::RPTS_ST_RUN;
      rpts_pkg::RPTS_ST_RUN:
        if (park_req)
        begin
          state_nxt = rpts_pkg::RPTS_ST_PARK;
          tmr_load  = 1'b1;
          tmr_count = 16'(PARK_CYCS);
        end
      rpts_pkg::RPTS_ST_PARK:
        if (tmr_done)
          state_nxt = rpts_pkg::RPTS_ST_PARKED;
      rpts_pkg::RPTS_ST_PARKED:
        state_nxt = rpts_pkg::RPTS_ST_PARKED;                      // only a reset leaves
      default:
        state_nxt = rpts_pkg::RPTS_ST_RESET;
    endcase
    if (por_low)
    begin
      state_nxt = rpts_pkg::RPTS_ST_RESET;
      tmr_load  = 1'b1;
      tmr_count = 16'h0000;
    end
  end

  rpts_delay_cnt #(
    .W (16)
  ) u_tmr (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_busy    (),
    .o_done    (tmr_done)
  );

  wire strap_take = (state_r == rpts_pkg::RPTS_ST_WAIT_STRAP) && tmr_done && !por_low;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_r <= rpts_pkg::RPTS_ST_RESET;
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // captured only on the single sampling cycle, so later pin activity cannot alter the mode
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      strap_r       <= rpts_pkg::STRAP_RST;
      strap_valid_r <= 1'b0;
    end
    else if (por_low)
    begin
      strap_r       <= rpts_pkg::STRAP_RST;
      strap_valid_r <= 1'b0;
    end
    else if (strap_take && !strap_valid_r)
    begin
      strap_r       <= i_test_strap_pin;
      strap_valid_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // test pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      oe_r   <= 1'b0;
      dout_r <= '0;
    end
    else if (por_low)
    begin
      oe_r   <= 1'b0;
      dout_r <= '0;
    end
    else
    begin
      if (strap_take)
        oe_r <= 1'b1;
      dout_r <= oe_r ? i_test_out_data : '0;
    end
  end

  // pulldown stays on always; it is weak and harmless when driving
  assign o_test_strap_drv.dout        = dout_r;
  assign o_test_strap_drv.oe          = {STRAP_W{oe_r && !por_low}};
  assign o_test_strap_drv.pulldown_en = {STRAP_W{1'b1}};

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  wire in_park   = (state_r == rpts_pkg::RPTS_ST_PARK);
  wire in_parked = (state_r == rpts_pkg::RPTS_ST_PARKED);

  assign o_status.cfg_busy    = !por_low && (state_r == rpts_pkg::RPTS_ST_CONFIG);
  assign o_status.ready       = !por_low && (state_r == rpts_pkg::RPTS_ST_RUN);
  assign o_status.parking     = !por_low && in_park;
  assign o_status.parked      = !por_low && in_parked;
  // strap registers clear one edge after the pin drops, so gate them to stay quiet at once
  assign o_status.strap_valid = !por_low && strap_valid_r;
  assign o_status.strap_value = por_low ? '0 : strap_r;

  assign o_test_mode              = !por_low && strap_valid_r && (strap_r != '0);
  assign o_micromirror_array_park = !por_low && (in_park || in_parked);
  // flags misuse of inputs the partner must keep low
  assign o_pin_misuse             = !por_low &&
                                    (i_factory_test_enable || i_scan_port_reset_n);

endmodule

`default_nettype wire

//--- tb/rpts_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rpts_chk #(
  parameter int SC = 8,
  parameter int CC = 4
) (
  input wire logic                    i_ref_clk,               // clock
  input wire logic                    i_resetn,                // reset
  input wire logic                    i_power_on_reset_n,      // reset pin
  input wire logic                    i_fast_park_n,           // park pin
  input wire logic [7:0]              i_test_strap_pin,        // pin levels
  input wire rpts_pkg::rpts_pin_drv_t o_test_strap_drv,        // pin drive
  input wire rpts_pkg::rpts_status_t  o_status,                // status
  input wire logic                    o_test_mode,             // mode
  input wire logic                    o_micromirror_array_park // park out
);
  localparam int SLO = SC - 8;
  localparam int SHI = SC - 5;
  localparam int CLO = CC - 1;
  localparam int CHI = CC + 2;
  wire logic por = i_power_on_reset_n;
  wire logic sv = o_status.strap_valid;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // --------------------------------------
  // a dropped reset pin only excuses a late event or a lost strap
  // --------------------------------------
  sequence s_rel; $rose(por); endsequence
  sequence s_cap; $rose(sv); endsequence
  property p_quiet; !por |-> o_status == '0 && !o_test_mode && !o_micromirror_array_park; endproperty
  a_quiet: assert property (p_quiet) else $error("active in reset");
  property p_float; !por |-> o_test_strap_drv.oe == 8'h00 && &o_test_strap_drv.pulldown_en; endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_late; s_rel |-> !sv [*8] ##[SLO:SHI] (sv || !por); endproperty
  a_late: assert property (p_late) else $error("strap timing");
  property p_val; s_cap |-> o_status.strap_value == $past(i_test_strap_pin); endproperty
  a_val: assert property (p_val) else $error("strap value");
  property p_mode; sv |-> o_test_mode == |o_status.strap_value; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_hold; sv && por |=> !por || sv && $stable(o_status.strap_value); endproperty
  a_hold: assert property (p_hold) else $error("strap changed");
  property p_cfg; s_cap |-> ##[CLO:CHI] (o_status.ready || !por); endproperty
  a_cfg: assert property (p_cfg) else $error("no ready");
  property p_park; !i_fast_park_n && o_status.ready |-> ##[0:3] (o_micromirror_array_park || !por); endproperty
  a_park: assert property (p_park) else $error("no park");
endmodule
bind rpts_ctrl rpts_chk #(.SC(STRAP_CYC), .CC(CFG_CYC)) u_chk (.i_ref_clk, .i_resetn, .i_power_on_reset_n,
  .i_fast_park_n, .i_test_strap_pin, .o_test_strap_drv, .o_status, .o_test_mode, .o_micromirror_array_park);
`default_nettype wire

//--- tb/rpts_pmic.sv
`timescale 1ns/100ps
`default_nettype none
module rpts_pmic (
  input  wire logic                    i_rel,    // supplies stable
  input  wire logic                    i_park,   // power loss
  input  wire logic                    i_bad,    // misuse on purpose
  input  wire logic [7:0]              i_ext,    // strap level
  input  wire logic                    i_ext_en, // strap driven
  input  wire rpts_pkg::rpts_pin_drv_t i_drv,    // device drive
  output logic                         o_por_n,  // reset pin
  output logic                         o_park_n, // park pin
  output logic                         o_ftest,  // test enable
  output logic                         o_scan_n, // scan reset
  output logic [7:0]                   o_pin     // pin level
);
  // --------------------------------------
  // undriven pins fall to the pulldown, or flip
  // --------------------------------------
  assign o_por_n = i_rel;
  assign o_park_n = !i_park;
  assign o_ftest = i_bad;
  assign o_scan_n = i_bad;
  assign o_pin = (i_drv.oe & i_drv.dout) | (~i_drv.oe & {8{i_ext_en}} & i_ext)
    | (~i_drv.oe & ~{8{i_ext_en}} & ~i_drv.pulldown_en & ~i_ext);
endmodule
`default_nettype wire

//--- tb/tb_reset_park_test_strap_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_reset_park_test_strap_ctrl;
  logic                    clk;
  logic                    rstn;
  logic                    rel;
  logic                    park;
  logic                    bad;
  logic                    ext_en;
  logic [7:0]              ext;
  logic [7:0]              tdat;
  logic [31:0]             seed;
  int                      err_count;
  int                      n_tests;
  wire logic               por_n, park_n, ftest, scan_n;
  wire logic [7:0]         pin;
  rpts_pkg::rpts_pin_drv_t drv;
  rpts_pkg::rpts_status_t  st;
  logic                    mode, apark, misuse;
  logic [7:0]              cor [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
  rpts_ctrl #(.STRAP_CYC(8), .CFG_CYC(4), .PARK_CYCS(4)) uut (.i_ref_clk(clk), .i_resetn(rstn),
    .i_power_on_reset_n(por_n), .i_fast_park_n(park_n), .i_factory_test_enable(ftest),
    .i_scan_port_reset_n(scan_n), .i_test_strap_pin(pin), .i_test_out_data(tdat), .o_test_strap_drv(drv),
    .o_status(st), .o_test_mode(mode), .o_micromirror_array_park(apark), .o_pin_misuse(misuse));
  rpts_pmic u_pmic (.i_rel(rel), .i_park(park), .i_bad(bad), .i_ext(ext), .i_ext_en(ext_en), .i_drv(drv),
    .o_por_n(por_n), .o_park_n(park_n), .o_ftest(ftest), .o_scan_n(scan_n), .o_pin(pin));
  // --------------------------------------
  // helpers
  // --------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_on(input int k);
    int n;
    n = 0;
    while ((k == 0 ? st.strap_valid : k == 1 ? st.ready : st.parked) !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    if (n == 200)
    begin
      err_count++;
      end_of_test();
    end
  endtask
  // pins released right after sampling, so the strap must survive the new pin levels
  task automatic boot(input logic [7:0] s, input logic do_park);
    ext = s;
    ext_en = 1'b1;
    tick(2);
    check(drv.oe, 8'h00);
    check(drv.pulldown_en, 8'hFF);
    check(8'({st.ready, st.strap_valid, mode, apark}), 8'h00);
    rel = 1'b1;
    tick(6);
    check(8'(st.strap_valid), 8'h00);
    wait_on(0);
    check(st.strap_value, s);
    check(8'(mode), 8'(s != 8'h00));
    check(8'(st.cfg_busy), 8'h01);
    ext_en = 1'b0;
    wait_on(1);
    check(8'(misuse), 8'h00);
    tdat = seed[15:8] ^ ~s;
    tick(2);
    check(drv.oe, 8'hFF);
    check(drv.dout, tdat);
    check(st.strap_value, s);
    if (do_park)
    begin
      park = 1'b1;
      tick(1);
      check(8'(st.parking), 8'h01);
      wait_on(2);
      check(8'(apark), 8'h01);
      park = 1'b0;
    end
    rel = 1'b0;
    tick(1);
    check(drv.oe, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rstn, rel, park, bad, ext_en} = '0;
    ext = 8'h00;
    tdat = 8'h00;
    seed = 32'hDF02E28B;
    err_count = 0;
    n_tests = 0;
    tick(12);
    rstn = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      boot(i < 4 ? cor[i] : seed[7:0], i[0]);
    end
    rel = 1'b1;
    bad = 1'b1;
    tick(1);
    check(8'(misuse), 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
